/* File: include/bcce_pkg.sv */
/*
  Constants, types and encodings for the branch/call/clear/watchdog execution block.
  Assumes a four-phase instruction cycle driven by a phase enable generated inside the core block.
*/
package bcce_pkg;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int SP_W = 5;
  localparam int ADDR_W = 12;
  localparam int STAT_W = 5;
  localparam int ZERO_BIT = 2;
  localparam int WDT_W = 8;
  localparam int POST_W = 16;
  localparam logic [7:0] OP_BZ_HI = 8'he0;
  localparam logic [6:0] OP_CALL_HI = 7'h76;
  localparam logic [3:0] OP_CALL2_PFX = 4'hf;
  localparam logic [6:0] OP_CLEAR_FILE_OP_HI = 7'h35;
  localparam logic [15:0] OP_CLEAR_WATCHDOG_OP = 16'h0004;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [7:0] DATA_CLEAR = 8'h00;

  typedef enum logic [3:0] {
    BCCE_Q1 = 4'h1, BCCE_Q2 = 4'h2, BCCE_Q3 = 4'h4, BCCE_Q4 = 4'h8
  } bcce_phase_t;

  typedef enum logic [2:0] {
    BCCE_EXEC = 3'h1, BCCE_FLUSH = 3'h2, BCCE_CALL2 = 3'h4
  } bcce_mode_t;

  // core registers that the shadow save copies
  typedef struct packed {
    logic [7:0] acc;
    logic [STAT_W-1:0] status;
    logic [3:0] bank;
  } bcce_core_t;

  // data memory write request
  typedef struct packed {
    logic we;
    logic indexed;
    logic [ADDR_W-1:0] addr;
    logic [7:0] idx_off;
    logic [7:0] data;
  } bcce_wr_t;

  typedef struct packed {
    bcce_phase_t phase;
    bcce_mode_t mode;
    logic [15:0] ir;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] top_of_stack;
    logic [SP_W-1:0] sp;
    logic [7:0] call_lo;
    logic call_s;
    logic [STAT_W-1:0] status;
    bcce_core_t shadow;
    bcce_wr_t wr;
    logic [WDT_W-1:0] wdt;
    logic [POST_W-1:0] post;
    logic to_n;
    logic pd_n;
    logic push;
    logic [PC_W-1:0] push_val;
  } bcce_state_t;
endpackage : bcce_pkg

/* File: logic/bcce_core.sv */
/*
  Executes branch-if-zero, two-word call, register clear and watchdog clear.
  Assumes program memory presents the word at PROG_ADDR by Q1 of each cycle and that other
  opcodes are executed elsewhere; the stack storage lives here, one entry per index.
*/
`timescale 1ns/1ps
module bcce_core
  import bcce_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // program memory
  input wire logic [15:0] PROG_WORD,
  output logic [PC_W-1:0] PROG_ADDR,
  // core registers and modes
  input wire logic [7:0] ACC_IN,
  input wire logic [3:0] BANK_SELECT_REG,
  input wire logic EXT_SET_EN,
  input wire logic WDT_TICK,
  // data memory write
  output bcce_wr_t DATA_WR,
  // status, shadow, stack, watchdog and phase
  output logic [STAT_W-1:0] STATUS_OUT,
  output bcce_core_t SHADOW_OUT,
  output logic [PC_W-1:0] TOP_OF_STACK,
  output logic [SP_W-1:0] STACK_PTR,
  output logic [WDT_W-1:0] WDT_COUNT,
  output logic [POST_W-1:0] WDT_POSTSCALE,
  output logic TIMEOUT_FLAG_N,
  output logic POWERDOWN_FLAG_N,
  output logic Q4_PHASE
);

  // ==========================================================================
  // decode helpers
  // ==========================================================================
  function automatic logic is_bz(input logic [15:0] w);
    return w[15:8] == OP_BZ_HI;
  endfunction : is_bz

  function automatic logic is_call(input logic [15:0] w);
    return w[15:9] == OP_CALL_HI;
  endfunction : is_call

  function automatic logic is_clear_file_op(input logic [15:0] w);
    return w[15:9] == OP_CLEAR_FILE_OP_HI;
  endfunction : is_clear_file_op

  function automatic logic [PC_W-1:0] sext2(input logic [7:0] n);
    return {{(PC_W-9){n[7]}}, n, 1'b0};
  endfunction : sext2

  // branch is taken only on a set zero flag
  function automatic logic take_branch(input logic [15:0] w, input logic [STAT_W-1:0] st);
    return is_bz(w) && st[ZERO_BIT];
  endfunction : take_branch

  // flushed cycles fetch nothing and execute nothing
  function automatic logic is_exec(input bcce_mode_t m);
    return m == BCCE_EXEC;
  endfunction : is_exec

  // second call word carries the all-ones prefix
  function automatic logic is_call2(input logic [15:0] w);
    return w[15:12] == OP_CALL2_PFX;
  endfunction : is_call2

  // watchdog clear is one exact word
  function automatic logic is_clear_watchdog_op(input logic [15:0] w);
    return w == OP_CLEAR_WATCHDOG_OP;
  endfunction : is_clear_watchdog_op

  // ==========================================================================
  // address arithmetic
  // ==========================================================================
  // address of the word after the current one
  function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] pc);
    return pc + PC_STEP;
  endfunction : next_pc

  // return address skips both words of the call
  function automatic logic [PC_W-1:0] ret_addr(input logic [PC_W-1:0] pc);
    return pc + PC_STEP + PC_STEP;
  endfunction : ret_addr

  // branch lands relative to the already advanced counter
  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc, input logic [7:0] n);
    return next_pc(pc) + sext2(n);
  endfunction : branch_target

  // literal fills counter bits 20:1; bit 0 stays clear
  function automatic logic [PC_W-1:0] call_target(input logic [11:0] hi, input logic [7:0] lo);
    return {hi, lo, 1'b0};
  endfunction : call_target

  // access bank is split; the banked form uses the bank select
  function automatic logic [ADDR_W-1:0] clear_addr(input logic [15:0] w, input logic [3:0] bank);
    logic [ADDR_W-1:0] a;
    if (w[8]) begin
      a = {bank, w[7:0]};
    end else if (w[7:0] < ACCESS_SPLIT) begin
      a = {4'h0, w[7:0]};
    end else begin
      a = {ACCESS_HI_BANK, w[7:0]};
    end
    return a;
  endfunction : clear_addr

  // low access addresses become offsets in extended mode
  function automatic logic clear_indexed(input logic [15:0] w, input logic ext);
    return ext && !w[8] && (w[7:0] <= IDX_LIMIT);
  endfunction : clear_indexed

  // a push lands in the entry just below the new pointer
  function automatic logic stk_hit(input logic [SP_W-1:0] sp, input int i);
    return sp == SP_W'(i + 1);
  endfunction : stk_hit

  // ==========================================================================
  // watchdog and phase
  // ==========================================================================
  // postscaler counts every tick
  function automatic logic [POST_W-1:0] post_step(input logic [POST_W-1:0] p, input logic tick);
    return tick ? p + POST_W'(1) : p;
  endfunction : post_step

  // counter advances when the postscaler wraps
  function automatic logic [WDT_W-1:0] wdt_step(input logic [WDT_W-1:0] w, input logic [POST_W-1:0] p, input logic tick);
    return (tick && (&p)) ? w + WDT_W'(1) : w;
  endfunction : wdt_step

  // four phases in a ring
  function automatic bcce_phase_t next_phase(input bcce_phase_t p);
    bcce_phase_t n;
    case (p)
      BCCE_Q1: n = BCCE_Q2;
      BCCE_Q2: n = BCCE_Q3;
      BCCE_Q3: n = BCCE_Q4;
      default: n = BCCE_Q1;
    endcase
    return n;
  endfunction : next_phase

  // ==========================================================================
  // reset image
  // ==========================================================================
  // counter at zero, active-low flags released, no write pending
  function automatic bcce_state_t reset_state();
    bcce_state_t r;
    r = '0;
    r.phase = BCCE_Q1;
    r.mode = BCCE_EXEC;
    r.ir = 16'h0000;
    r.pc = PC_RESET;
    r.top_of_stack = PC_RESET;
    r.sp = '0;
    r.call_lo = 8'h00;
    r.call_s = 1'b0;
    r.status = '0;
    r.shadow.acc = 8'h00;
    r.shadow.status = '0;
    r.shadow.bank = 4'h0;
    r.wr.we = 1'b0;
    r.wr.indexed = 1'b0;
    r.wr.addr = '0;
    r.wr.idx_off = 8'h00;
    r.wr.data = 8'h00;
    r.wdt = '0;
    r.post = '0;
    r.to_n = 1'b1;
    r.pd_n = 1'b1;
    r.push = 1'b0;
    r.push_val = PC_RESET;
    return r;
  endfunction : reset_state

  // ==========================================================================
  // state
  // ==========================================================================
  bcce_state_t s_r;
  bcce_state_t s_nxt;
  logic [PC_W-1:0] stack_r [STK_DEPTH];

  always_comb begin
    s_nxt = s_r;
    s_nxt.phase = next_phase(s_r.phase);
    s_nxt.push = 1'b0;
    s_nxt.wr.we = 1'b0;
    // watchdog runs from an external tick; clear below overrides it
    s_nxt.post = post_step(s_r.post, WDT_TICK);
    s_nxt.wdt = wdt_step(s_r.wdt, s_r.post, WDT_TICK);

    case (s_r.phase)
      // fetch; a flushed cycle keeps the old word and runs as a no-op
      BCCE_Q1: begin
        if (is_exec(s_r.mode)) begin
          s_nxt.ir = PROG_WORD;
        end
      end

      // low literal of a call
      BCCE_Q2: begin
        if (is_exec(s_r.mode) && is_call(s_r.ir)) begin
          s_nxt.call_lo = s_r.ir[7:0];
          s_nxt.call_s = s_r.ir[8];
        end
      end

      // push the return address; take the fast-save copy only when the call's s bit is set
      BCCE_Q3: begin
        if (is_exec(s_r.mode) && is_call(s_r.ir)) begin
          s_nxt.push = 1'b1;
          s_nxt.push_val = ret_addr(s_r.pc);
          s_nxt.top_of_stack = ret_addr(s_r.pc);
          s_nxt.sp = s_r.sp + 5'h01;
          if (s_r.call_s) begin
            s_nxt.shadow = '{acc: ACC_IN, status: s_r.status, bank: BANK_SELECT_REG};
          end
        end
      end

      // write back; after a flush the counter already holds the target
      BCCE_Q4: begin
        s_nxt.mode = BCCE_EXEC;
        if (is_exec(s_r.mode)) begin
          s_nxt.pc = next_pc(s_r.pc);
          if (take_branch(s_r.ir, s_r.status)) begin
            s_nxt.pc = branch_target(s_r.pc, s_r.ir[7:0]);
            s_nxt.mode = BCCE_FLUSH;
          end else if (is_call(s_r.ir)) begin
            // second word is shown by program memory during Q4
            if (is_call2(PROG_WORD)) begin
              s_nxt.pc = call_target(PROG_WORD[11:0], s_r.call_lo);
            end
            s_nxt.mode = BCCE_FLUSH;
          end else if (is_clear_file_op(s_r.ir)) begin
            s_nxt.wr.we = 1'b1;
            s_nxt.wr.data = DATA_CLEAR;
            s_nxt.wr.idx_off = s_r.ir[7:0];
            s_nxt.wr.indexed = clear_indexed(s_r.ir, EXT_SET_EN);
            s_nxt.wr.addr = clear_addr(s_r.ir, BANK_SELECT_REG);
            s_nxt.status[ZERO_BIT] = 1'b1;
          end else if (is_clear_watchdog_op(s_r.ir)) begin
            s_nxt.wdt = '0;
            s_nxt.post = '0;
            s_nxt.to_n = 1'b1;
            s_nxt.pd_n = 1'b1;
          end
          // other flags untouched by these opcodes
        end
      end
      default: begin
        s_nxt.phase = BCCE_Q1;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= reset_state();
    end else begin
      s_r <= s_nxt;
    end
  end

  // stack storage, written one cycle after the push decision
  generate
    for (genvar i = 0; i < STK_DEPTH; i++) begin : g_stk
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          stack_r[i] <= PC_RESET;
        end else if (s_r.push && stk_hit(s_r.sp, i)) begin
          stack_r[i] <= s_r.push_val;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // outputs
  // ==========================================================================
  // program memory and data memory
  assign PROG_ADDR = s_r.pc;
  assign DATA_WR = s_r.wr;
  // status, shadows and stack
  assign STATUS_OUT = s_r.status;
  assign SHADOW_OUT = s_r.shadow;
  assign TOP_OF_STACK = s_r.top_of_stack;
  assign STACK_PTR = s_r.sp;
  // watchdog and its flags
  assign WDT_COUNT = s_r.wdt;
  assign WDT_POSTSCALE = s_r.post;
  assign TIMEOUT_FLAG_N = s_r.to_n;
  assign POWERDOWN_FLAG_N = s_r.pd_n;
  // phase marker for program memory
  assign Q4_PHASE = (s_r.phase == BCCE_Q4);

endmodule : bcce_core

/* File: verif/bcce_core_chk.sv */
/* checker for bcce_core ports; bound at the foot */
`timescale 1ns/1ps
module bcce_core_chk
  import bcce_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] ACC_IN,
  input wire bcce_wr_t DATA_WR,
  input wire logic [STAT_W-1:0] STATUS_OUT,
  input wire bcce_core_t SHADOW_OUT,
  input wire logic [PC_W-1:0] PROG_ADDR,
  input wire logic [PC_W-1:0] TOP_OF_STACK,
  input wire logic [SP_W-1:0] STACK_PTR,
  input wire logic TIMEOUT_FLAG_N,
  input wire logic Q4_PHASE
);
  // ==========
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_we_pulse: assert property (DATA_WR.we |=> !DATA_WR.we) else $error("write held");
  a_we_zero: assert property (DATA_WR.we |-> DATA_WR.data == 8'h00) else $error("nonzero clear");
  a_clr_zflag: assert property ($rose(DATA_WR.we) |-> ##[0:4] STATUS_OUT[ZERO_BIT]) else $error("no z");
  a_sp_step: assert property ($changed(STACK_PTR) |-> STACK_PTR == $past(STACK_PTR) + 5'h1)
    else $error("bad push");
  a_push_ret: assert property ($changed(STACK_PTR) |-> TOP_OF_STACK == PROG_ADDR + 21'h4)
    else $error("bad return");
  a_phase_ring: assert property (Q4_PHASE |=> !Q4_PHASE [*3] ##1 Q4_PHASE) else $error("phase");
  a_shadow_acc: assert property ($changed(SHADOW_OUT) |-> SHADOW_OUT.acc == $past(ACC_IN))
    else $error("shadow");
  a_status_keep: assert property ($changed(STATUS_OUT) |-> STATUS_OUT[ZERO_BIT]) else $error("flags");
  a_to_keep: assert property (!$fell(TIMEOUT_FLAG_N)) else $error("timeout flag");
  c_write: cover property (DATA_WR.we);
  c_push: cover property ($changed(STACK_PTR));
  c_shadow: cover property ($changed(SHADOW_OUT));
endmodule : bcce_core_chk
bind bcce_core bcce_core_chk u_chk (.CLK, .RST_N, .ACC_IN, .DATA_WR, .STATUS_OUT, .SHADOW_OUT,
  .PROG_ADDR, .TOP_OF_STACK, .STACK_PTR, .TIMEOUT_FLAG_N, .Q4_PHASE);

/* File: verif/bcce_prog_mem.sv */
/* program memory model; the bench loads the word array */
`timescale 1ns/1ps
module bcce_prog_mem
  import bcce_pkg::*;
(
  input wire logic [PC_W-1:0] addr,
  input wire logic q4,
  output logic [15:0] word
);
  logic [15:0] mem [256];
  // in q4 the next word is shown for a call's second half
  assign word = q4 ? mem[8'(addr[8:1] + 8'h1)] : mem[addr[8:1]];
endmodule : bcce_prog_mem

/* File: verif/bcce_core_bench.sv */
/* bench for bcce_core; program comes from bcce_prog_mem */
`timescale 1ns/1ps
module bcce_core_bench;
  import bcce_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] acc = 8'ha5;
  logic tick = 1'b1;
  logic [15:0] pw;
  logic [PC_W-1:0] pc, top_of_stack;
  bcce_wr_t wr;
  logic [STAT_W-1:0] st;
  bcce_core_t sh;
  logic [SP_W-1:0] sp;
  logic [WDT_W-1:0] wdt;
  logic [POST_W-1:0] post;
  logic to_n, pd_n, q4;
  logic [12:0] wq [$];
  int fail_count = 0;
  int comparisons = 0;
  int n;
  // ==========
  // plumbing
  initial forever #2.5 clk = ~clk;
  bcce_prog_mem u_mem (.addr(pc), .q4(q4), .word(pw));
  bcce_core uut (.CLK(clk), .RST_N(rst_n), .PROG_WORD(pw), .PROG_ADDR(pc), .ACC_IN(acc),
    .BANK_SELECT_REG(4'h3), .EXT_SET_EN(1'b1), .WDT_TICK(tick), .DATA_WR(wr), .STATUS_OUT(st),
    .SHADOW_OUT(sh), .TOP_OF_STACK(top_of_stack), .STACK_PTR(sp), .WDT_COUNT(wdt), .WDT_POSTSCALE(post),
    .TIMEOUT_FLAG_N(to_n), .POWERDOWN_FLAG_N(pd_n), .Q4_PHASE(q4));
  always @(posedge clk) if (wr.we) wq.push_back({wr.indexed, wr.addr});
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_pc(logic [PC_W-1:0] t);
    n = 0;
    while (pc !== t && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("pc", 32'(t), 32'(pc));
  endtask : wait_pc
  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // ==========
  // scenarios
  task automatic t_skip_clear;
    wait_pc(21'h2);
    wait_pc(21'h4);
    chk("cycles", 4, n);
    @(negedge clk);
    chk("zero", 1, st[ZERO_BIT]);
    chk("writes", 1, wq.size());
    chk("wr0", {1'b1, 12'h020}, wq[0]);
    $display("done skip_clear");
  endtask : t_skip_clear
  task automatic t_branch_call;
    wait_pc(21'ha);
    wait_pc(21'h80);
    chk("call cycles", 8, n);
    chk("tos", 21'he, top_of_stack);
    chk("sp", 1, sp);
    chk("shadow", {8'ha5, st, 4'h3}, sh);
    chk("flushed", 1, wq.size());
    chk("zero kept", 1, st[ZERO_BIT]);
    @(posedge clk);
    tick <= 1'b0;
    $display("done branch_call");
  endtask : t_branch_call
  task automatic t_bank_wdt;
    wait_pc(21'h88);
    chk("writes", 2, wq.size());
    chk("wr1", {1'b0, 12'h312}, wq[1]);
    chk("wdt", 0, wdt);
    chk("post", 0, post);
    chk("flags", 2'b11, {to_n, pd_n});
    $display("done bank_wdt");
  endtask : t_bank_wdt
  initial begin
    foreach (u_mem.mem[i]) u_mem.mem[i] = 16'h0000;
    u_mem.mem[0] = 16'he005;
    u_mem.mem[1] = 16'h6a20;
    u_mem.mem[2] = 16'he002;
    u_mem.mem[3] = 16'h6a55;
    u_mem.mem[4] = 16'h6a66;
    u_mem.mem[5] = 16'hed40;
    u_mem.mem[6] = 16'hf000;
    u_mem.mem[64] = 16'h6b12;
    u_mem.mem[65] = 16'h0004;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_skip_clear();
    t_branch_call();
    t_bank_wdt();
    end_sim();
  end
  initial begin
    #5000;
    fail_count++;
    end_sim();
  end
endmodule : bcce_core_bench
